// ===== rtl/dtdu_top.sv
// Notes on behaviour
// - In toggle mode a falling pin edge loads each enabled channel that selects that pin from A.
// - In toggle mode a rising pin edge loads each enabled channel that selects that pin from B.
// - In dither mode the pins are dither clocks that the host supplies.
// - In dither mode the outputs change only on a rising dither clock edge, an update or a clear.
// - Only channels whose enable bit is 1 react to toggle/dither edges.
// - A grounded compensation pin at power-up leaves the internal ref off.
// - By default the internal reference is driven onto the reference pin.
// - External reference mode stops driving the pin, leaving it an input.
// - Clear low forces zero-scale code, 0-5 V span and default controls.
// - Update pin falling while select/load is high copies A into all DACs.
`timescale 1ns/1ps
`default_nettype none
module dtdu_top #(
  parameter int N = dtdu_pkg::N_CH,
  parameter int W = dtdu_pkg::CODE_W
) (
  input wire logic clk,  // 100 MHz system clock
  input wire logic rst_b,  // Asynchronous reset, active low
  input wire logic [dtdu_pkg::PIN_CNT-1:0] toggleDitherPin,  // Toggle pins
  input wire logic dacUpdateN,  // Update pin, active low
  input wire logic selectAndLoadN,  // Chip select/load pin, active low
  input wire logic asyncClearN,  // Clear level, active low
  input wire logic referenceCompensationPin,  // High: cap, low: grounded
  input wire logic ctrlWrite,  // One-cycle strobe for control inputs
  input wire logic [N-1:0] channelToggleEnable,  // Per-channel enable
  input wire logic [N-1:0] channelDitherMode,  // 1: dither, 0: toggle
  input wire logic [N-1:0][dtdu_pkg::SEL_W-1:0] channelPinSel,  // Pin index
  input wire logic [N-1:0][dtdu_pkg::SPAN_W-1:0] channelSpan,  // Span code
  input wire logic extRefSelect,  // 1: external reference mode
  input wire logic [N-1:0][W-1:0] inputRegA,  // Input register A
  input wire logic [N-1:0][W-1:0] inputRegB,  // Input register B
  input wire logic [N-1:0][W-1:0] ditherCode,  // Next dither sample
  output logic [N-1:0][W-1:0] dacCode,  // DAC register contents
  output logic [N-1:0][dtdu_pkg::SPAN_W-1:0] spanCode,  // Active span
  output logic [N-1:0] enableState,  // Registered channel enables
  output logic intRefEnable,  // Internal reference powered
  output logic refDriveEn  // High while driving the reference pin
);
  import dtdu_pkg::*;

  typedef struct packed {
    logic [N-1:0][W-1:0] dac;
    logic [N-1:0][SPAN_W-1:0] span;
    logic [N-1:0] en;
    logic [N-1:0] dith;
    logic [N-1:0][SEL_W-1:0] sel;
    logic extRef;
    logic intRefOk;
    logic strapDone;
  } dtdu_state_t;

  dtdu_state_t state_reg;
  dtdu_state_t state_next;
  logic [1:0] rstSync_reg;
  logic rstN;
  logic [EDGE_W-1:0] edgeRise;
  logic [EDGE_W-1:0] edgeFall;
  logic updateEvent;

  // Pick the edge of the pin a channel listens to; index 3 means none
  function automatic logic pickEdge(input logic [EDGE_W-1:0] edges,
                                    input logic [SEL_W-1:0] sel);
    logic hit;
    hit = 1'b0;
    if (sel < SEL_W'(PIN_CNT)) begin
      hit = edges[sel];
    end
    return hit;
  endfunction : pickEdge

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstN = rstSync_reg[1];

  // Edge detection on pins, free of any serial clock
  dtdu_edge_detect #(
    .W(EDGE_W)
  ) u_edges (
    .clk(clk),
    .rstN(rstN),
    .level({selectAndLoadN, dacUpdateN, toggleDitherPin}),
    .rise(edgeRise),
    .fall(edgeFall)
  );

  // Update pin falls with select high, or select rises with update low
  assign updateEvent = (edgeFall[LANE_UPDATE] && selectAndLoadN) ||
                       (edgeRise[LANE_SELECT] && !dacUpdateN);

  // Next-state logic: clear beats update, update beats toggle and dither
  always_comb begin
    logic r;
    logic f;
    r = 1'b0;
    f = 1'b0;
    state_next = state_reg;
    // Strap caught in the first cycle after reset release
    if (!state_reg.strapDone) begin
      state_next.strapDone = 1'b1;
      state_next.intRefOk = referenceCompensationPin;
    end
    if (!asyncClearN) begin
      for (int c = 0; c < N; c++) begin
        state_next.dac[c] = CODE_ZERO_SCALE;
        state_next.span[c] = SPAN_0_TO_5V;
        state_next.sel[c] = SEL_RESET;
        state_next.en[c] = EN_RESET;
        state_next.dith[c] = DITHER_RESET;
      end
      state_next.extRef = EXT_REF_RESET;
    end else begin
      if (ctrlWrite) begin
        state_next.en = channelToggleEnable;
        state_next.dith = channelDitherMode;
        state_next.sel = channelPinSel;
        state_next.span = channelSpan;
        state_next.extRef = extRefSelect;
      end
      if (updateEvent) begin
        state_next.dac = inputRegA;
      end else begin
        for (int c = 0; c < N; c++) begin
          r = pickEdge(edgeRise, state_reg.sel[c]);
          f = pickEdge(edgeFall, state_reg.sel[c]);
          if (state_reg.en[c]) begin
            if (state_reg.dith[c]) begin
              // Pin is a dither clock; only its rising edge steps the output
              if (r) begin
                state_next.dac[c] = ditherCode[c];
              end
            end else if (f) begin
              state_next.dac[c] = inputRegA[c];
            end else if (r) begin
              state_next.dac[c] = inputRegB[c];
            end
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign dacCode = state_reg.dac;
  assign spanCode = state_reg.span;
  assign enableState = state_reg.en;
  // Internal ref on unless strapped off or external mode chosen
  assign intRefEnable = state_reg.strapDone && state_reg.intRefOk &&
                        !state_reg.extRef;
  assign refDriveEn = intRefEnable;

  // Checks on channel 0, plus clear, update and reference checks on all channels
  logic fallHit0;
  logic riseHit0;
  logic ditherFall0;
  assign fallHit0 = asyncClearN && !updateEvent && state_reg.en[0] &&
                    !state_reg.dith[0] && pickEdge(edgeFall, state_reg.sel[0]);
  assign riseHit0 = asyncClearN && !updateEvent && state_reg.en[0] &&
                    !state_reg.dith[0] && pickEdge(edgeRise, state_reg.sel[0])
                    && !pickEdge(edgeFall, state_reg.sel[0]);
  assign ditherFall0 = asyncClearN && !updateEvent && state_reg.en[0] &&
                       state_reg.dith[0] &&
                       !pickEdge(edgeRise, state_reg.sel[0]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  a_fall_loads_a: assert property (
    fallHit0 |=> dacCode[0] == $past(inputRegA[0]))
    else $error("Falling toggle edge did not load register A");
  a_rise_loads_b: assert property (
    riseHit0 |=> dacCode[0] == $past(inputRegB[0]))
    else $error("Rising toggle edge did not load register B");
  a_dither_rise_only: assert property (
    ditherFall0 |=> $stable(dacCode[0]))
    else $error("Dither output changed without a rising edge");
  a_disabled_ignores: assert property (
    (asyncClearN && !updateEvent && !state_reg.en[0]) |=> $stable(dacCode[0]))
    else $error("Disabled channel reacted to a pin edge");
  a_clear_defaults: assert property (
    !asyncClearN |=> (dacCode == '0) && (spanCode == '0) &&
                     (enableState == '0) ##1 (!asyncClearN || dacCode == '0 ||
                     $past(updateEvent) || $past(|edgeRise[PIN_CNT-1:0]) ||
                     $past(|edgeFall[PIN_CNT-1:0])))
    else $error("Clear did not force zero scale and defaults");
  a_update_copies_a: assert property (
    (updateEvent && asyncClearN) |=> dacCode == $past(inputRegA))
    else $error("Update pin did not copy register A into all channels");
  a_strap_ground_off: assert property (
    ($rose(state_reg.strapDone) && !$past(referenceCompensationPin))
    |-> !intRefEnable [*3])
    else $error("Internal reference on despite grounded strap");
  a_default_ref_route: assert property (
    ($rose(state_reg.strapDone) && $past(referenceCompensationPin) &&
     !state_reg.extRef) |-> refDriveEn)
    else $error("Internal reference not routed to pin by default");
  a_ext_ref_hiz: assert property (
    state_reg.extRef |-> !refDriveEn && !intRefEnable)
    else $error("Reference pin driven in external reference mode");

  c_fall_toggle: cover property (fallHit0 ##1 riseHit0);
  c_dither_step: cover property (state_reg.dith[0] && state_reg.en[0] &&
                                 pickEdge(edgeRise, state_reg.sel[0]));
  c_update_event: cover property (updateEvent && asyncClearN);
  c_clear_pulse: cover property (!asyncClearN ##1 asyncClearN);
endmodule : dtdu_top
`default_nettype wire

// ===== rtl/dtdu_pkg.sv
`default_nettype none
package dtdu_pkg;
  // Channel count and code width as built
  localparam int N_CH = 8;
  localparam int CODE_W = 16;
  // Toggle/dither pin count and per-channel pin select width
  localparam int PIN_CNT = 3;
  localparam int SEL_W = 2;
  // Span code width and the span forced by a clear (0 V to 5 V)
  localparam int SPAN_W = 3;
  localparam logic [SPAN_W-1:0] SPAN_0_TO_5V = 3'h0;
  // Reset and clear values of the channel state
  localparam logic [CODE_W-1:0] CODE_ZERO_SCALE = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam logic EN_RESET = 1'b0;
  localparam logic DITHER_RESET = 1'b0;
  localparam logic EXT_REF_RESET = 1'b0;
  // Edge detector lanes: three toggle pins, update pin, select/load pin
  localparam int EDGE_W = 5;
  localparam int LANE_UPDATE = 3;
  localparam int LANE_SELECT = 4;
endpackage : dtdu_pkg
`default_nettype wire

// ===== rtl/dtdu_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module dtdu_edge_detect #(
  parameter int W = 5
) (
  input wire logic clk,  // System clock
  input wire logic rstN,  // Synchronised reset, active low
  input wire logic [W-1:0] level,  // Sampled pin levels
  output logic [W-1:0] rise,  // Rising edge seen this cycle
  output logic [W-1:0] fall  // Falling edge seen this cycle
);
  typedef struct packed {
    logic primed;
    logic [W-1:0] prev;
  } dtdu_edge_state_t;

  dtdu_edge_state_t state_reg;
  dtdu_edge_state_t state_next;

  // Edges come from pin history alone, no serial activity needed
  assign rise = state_reg.primed ? (level & ~state_reg.prev) : '0;
  assign fall = state_reg.primed ? (~level & state_reg.prev) : '0;

  // First cycle after reset only learns the levels, so no false edge
  always_comb begin
    state_next = state_reg;
    state_next.primed = 1'b1;
    state_next.prev = level;
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : dtdu_edge_detect
`default_nettype wire

// ===== test/dtdu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtdu_host_model (
  input wire logic clk,  // System clock
  input wire logic rstN,  // Bench reset, active low
  input wire logic cmdValid,  // One-cycle pin command
  input wire logic [2:0] cmdPin,  // 0-2 toggle, 3 update, 4 select pin
  input wire logic cmdLevel,  // Level to drive on that pin
  output logic [dtdu_pkg::PIN_CNT-1:0] toggleDitherPin,  // Toggle pins
  output logic dacUpdateN,  // Update pin, active low
  output logic selectAndLoadN  // Select/load pin, active low
);
  import dtdu_pkg::*;
  // Toggle pins idle low, update and select idle high; one pin moves per command, one edge later
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      toggleDitherPin <= 3'h0;
      dacUpdateN <= 1'b1;
      selectAndLoadN <= 1'b1;
    end else if (cmdValid) begin
      if (cmdPin == 3'h4) begin
        selectAndLoadN <= cmdLevel;
      end else if (cmdPin == 3'h3) begin
        dacUpdateN <= cmdLevel;
      end else begin
        toggleDitherPin[cmdPin[1:0]] <= cmdLevel;
      end
    end
  end
endmodule : dtdu_host_model
`default_nettype wire

// ===== test/test_dac_toggle_dither_update.sv
`timescale 1ns/1ps
`default_nettype none
module test_dac_toggle_dither_update;
  import dtdu_pkg::*;
  typedef struct {
    logic [N_CH-1:0][CODE_W-1:0] dac;
    logic [N_CH-1:0][SPAN_W-1:0] span;
    logic [N_CH-1:0] en;
    logic refOn;
  } dtdu_exp_t;
  logic clk, rst_b, clearN, strap, ctrlWrite, extRef, cmdValid, cmdLevel;
  logic [2:0] cmdPin;
  logic [PIN_CNT-1:0] pins;
  logic updN, selN, intRef, refDrv;
  logic [N_CH-1:0] en, dith, enO;
  logic [N_CH-1:0][SEL_W-1:0] sel;
  logic [N_CH-1:0][SPAN_W-1:0] span, spanO;
  logic [N_CH-1:0][CODE_W-1:0] a, b, d, dac;
  dtdu_exp_t cur, e;
  dtdu_exp_t q[$];
  int failCount, samplesChecked;
  event due;
  dtdu_host_model host (.clk(clk), .rstN(rst_b), .cmdValid(cmdValid),
    .cmdPin(cmdPin), .cmdLevel(cmdLevel), .toggleDitherPin(pins),
    .dacUpdateN(updN), .selectAndLoadN(selN));
  dtdu_top dut (.clk(clk), .rst_b(rst_b), .toggleDitherPin(pins),
    .dacUpdateN(updN), .selectAndLoadN(selN), .asyncClearN(clearN),
    .referenceCompensationPin(strap), .ctrlWrite(ctrlWrite),
    .channelToggleEnable(en), .channelDitherMode(dith),
    .channelPinSel(sel), .channelSpan(span), .extRefSelect(extRef),
    .inputRegA(a), .inputRegB(b), .ditherCode(d), .dacCode(dac),
    .spanCode(spanO), .enableState(enO), .intRefEnable(intRef),
    .refDriveEn(refDrv));
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task step();
    @(posedge clk);
    #1;
  endtask : step
  task note();
    q.push_back(cur);
    ->due;
  endtask : note
  task chk(input string nm, input logic [127:0] ex, input logic [127:0] sn);
    samplesChecked++;
    if (sn !== ex) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  // Monitor: oldest note against the settled outputs
  initial forever begin
    @(due);
    e = q.pop_front();
    chk("dacCode", e.dac, dac);
    chk("spanCode", e.span, spanO);
    chk("enableState", e.en, enO);
    chk("intRefEnable", e.refOn, intRef);
    chk("refDriveEn", e.refOn, refDrv);
  end
  task stopTest();
    $display("Checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stopTest
  // Reset held 6 cycles, then wait past strap sampling and edge learning
  task rst(input logic s);
    rst_b = 1'b0;
    strap = s;
    repeat (6) step();
    rst_b = 1'b1;
    repeat (6) step();
    cur = '{default: '0};
    cur.refOn = s;
  endtask : rst
  // New random pin selects (channel 0 fixed on pin 0), spans, enables and sources, dither mode and reference mode from the arguments, captured by one strobe
  task ctrl(input logic [N_CH-1:0] dm, input logic x);
    for (int c = 0; c < N_CH; c++) begin
      sel[c] = (c == 0) ? 2'h0 : 2'($urandom_range(3, 0));
      span[c] = 3'($urandom);
      a[c] = 16'($urandom);
      b[c] = 16'($urandom);
      d[c] = 16'($urandom);
    end
    en = 8'($urandom) | 8'h11;
    dith = dm;
    extRef = x;
    ctrlWrite = 1'b1;
    step();
    ctrlWrite = 1'b0;
    cur.en = en;
    cur.span = span;
    cur.refOn = strap & ~x;
  endtask : ctrl
  // One pin edge through the host; expected codes follow per channel
  task pin(input int p, input logic lvl);
    cmdPin = 3'(p);
    cmdLevel = lvl;
    cmdValid = 1'b1;
    step();
    cmdValid = 1'b0;
    step();
    for (int c = 0; c < N_CH; c++) begin
      if (p == 4) begin
        if (lvl && !updN) cur.dac[c] = a[c];
      end else if (p == 3) begin
        if (!lvl && selN) cur.dac[c] = a[c];
      end else if (cur.en[c] && sel[c] == 2'(p)) begin
        if (!dith[c]) cur.dac[c] = lvl ? b[c] : a[c];
        else if (lvl) cur.dac[c] = d[c];
      end
    end
  endtask : pin
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    $display("ERROR run expected end seen hang");
    stopTest();
  end
  // Main sequence
  initial begin
    {rst_b, strap, clearN, ctrlWrite, extRef, cmdValid, cmdLevel} = 7'h30;
    {cmdPin, en, dith, sel, span, a, b, d} = '0;
    void'($urandom(28744));
    rst(1'b1);
    note();
    ctrl(8'h00, 1'b0);
    note();
    for (int i = 0; i < PIN_CNT; i++) begin
      pin(i, 1'b1);
      note();
      pin(i, 1'b0);
      note();
    end
    ctrl(8'hF1, 1'b0);
    for (int i = 0; i < PIN_CNT; i++) begin
      pin(i, 1'b1);
      note();
      pin(i, 1'b0);
      note();
    end
    pin(3, 1'b0);
    note();
    pin(3, 1'b1);
    note();
    ctrl(8'h00, 1'b1);
    note();
    // Select low: update fall refused; select rise with update low loads A
    pin(4, 1'b0);
    pin(3, 1'b0);
    note();
    pin(4, 1'b1);
    note();
    pin(3, 1'b1);
    clearN = 1'b0;
    step();
    cur = '{default: '0};
    cur.refOn = strap;
    note();
    clearN = 1'b1;
    pin(0, 1'b1);
    note();
    rst(1'b0);
    note();
    step();
    stopTest();
  end
endmodule : test_dac_toggle_dither_update
`default_nettype wire
